// [hw/dlc_defs.svh]
`ifndef DLC_DEFS_SVH
`define DLC_DEFS_SVH
// byte offsets
`define DLC_OFS_LEN      8'h00
`define DLC_OFS_DIAG     8'h04
`define DLC_OFS_CTRL     8'h08
`define DLC_OFS_INTFLAG  8'h0c
`define DLC_OFS_ENABLE   8'h10
// diagnostic register fields
`define DLC_DIAG_LITE_BIT   28
`define DLC_DIAG_LITE_VAL   1'h1
`define DLC_DIAG_REV_HI     27
`define DLC_DIAG_REV_LO     25
// revision value is arbitrary
`define DLC_DIAG_REV_VAL    3'h5
`define DLC_DIAG_ST_HI      24
`define DLC_DIAG_ST_LO      16
`define DLC_DIAG_ID_HI      15
`define DLC_DIAG_ID_LO      8
`define DLC_DIAG_OW_HI      7
`define DLC_DIAG_OW_LO      4
`define DLC_DIAG_RDERR_BIT  2
`define DLC_DIAG_FFERR_BIT  1
`define DLC_DIAG_LSTERR_BIT 0
// control register fields
`define DLC_CTRL_ACTIVE_BIT 0
`define DLC_CTRL_IRQ_BIT    1
`define DLC_CTRL_ERR_BIT    2
// reset values
`define DLC_LEN_RST      16'h0000
`define DLC_INTFLAG_RST  16'h0000
`define DLC_ENABLE_RST   15'h7fff
`endif

// [hw/dlc_pkg.sv]
package dlc_pkg;
  typedef enum logic [1:0] {
    DLC_IDLE,
    DLC_RUN,
    DLC_DRAIN
  } dlc_state_type;

  typedef struct packed {
    logic [3:0] cnt;
  } dlc_owc_type;
endpackage : dlc_pkg

// [hw/dlc_err_flag.sv]
`timescale 1ns/1ps
// sticky flag: hardware set wins over write-one-to-clear
module dlc_err_flag
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // events
  input  wire logic set_i,
  input  wire logic clr_i,
  // state
  output logic      flag_o
);
  typedef struct packed {
    logic flag;
  } dlc_flag_type;

  dlc_flag_type s_q;
  dlc_flag_type s_d;

  always_comb
  begin
    s_d = s_q;
    if (set_i)
    begin
      s_d.flag = 1'b1;
    end
    else if (clr_i)
    begin
      s_d.flag = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign flag_o = s_q.flag;

  chk_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.flag && !clr_i |=> s_q.flag)
    else $error("error flag dropped without clear");
  chk_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
    set_i |=> s_q.flag)
    else $error("error flag not set by event");
endmodule : dlc_err_flag

// [hw/dlc_channel.sv]
`timescale 1ns/1ps
`include "dlc_defs.svh"
module dlc_channel #(
  parameter logic [7:0] BUS_ID  = 8'h00,
  parameter int         NUM_ENG = 16,
  parameter int         NUM_EN  = 15
)
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // transfer progress
  input  wire logic        start_i,
  input  wire logic        beat_i,
  input  wire logic [4:0]  beat_bytes_i,
  input  wire logic        wr_issue_i,
  input  wire logic        wr_resp_i,
  // error events
  input  wire logic        rd_resp_err_i,
  input  wire logic        fifo_err_i,
  input  wire logic        rd_last_miss_i,
  input  wire logic [NUM_ENG-1:0] eng_irq_i,
  // status to the engine
  output logic             active_o,
  output logic             irq_o,
  output logic [NUM_EN-1:0] eng_on_o,
  output logic [7:0]       bus_transaction_id_o
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [15:0]         transfer_byte_count;
    dlc_pkg::dlc_owc_type owc;
    dlc_pkg::dlc_state_type st;
    logic                active;
    logic                irq;
    logic                ack;
    logic [31:0]         rdata;
    logic [NUM_ENG-1:0]  irq_flags;
    logic [NUM_EN-1:0]   eng_on;
  } dlc_regs_type;

  dlc_regs_type s_q;
  dlc_regs_type s_d;

  logic       req;
  logic       wr;
  logic [2:0] err;
  logic [2:0] err_clr;
  logic [2:0] err_set;
  logic [31:0] diag;
  logic [31:0] ctrl;

  assign req = cyc_i && stb_i && !s_q.ack;
  assign wr  = req && we_i;

  // ==========================================================
  // error flags
  assign err_set = {rd_resp_err_i, fifo_err_i, rd_last_miss_i};
  // only a one written clears, zero bits hold
  assign err_clr = (wr && adr_i == `DLC_OFS_DIAG && sel_i[0]) ? dat_i[2:0] : 3'h0;

  for (genvar g = 0; g < 3; g++)
  begin : g_err
    dlc_err_flag u_flag (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .set_i  (err_set[g]),
      .clr_i  (err_clr[g]),
      .flag_o (err[g])
    );
  end

  // ==========================================================
  // read views
  always_comb
  begin
    diag = 32'h0;
    diag[`DLC_DIAG_LITE_BIT] = `DLC_DIAG_LITE_VAL;
    diag[`DLC_DIAG_REV_HI:`DLC_DIAG_REV_LO] = `DLC_DIAG_REV_VAL;
    diag[`DLC_DIAG_ST_HI:`DLC_DIAG_ST_LO] = 9'(s_q.st);
    diag[`DLC_DIAG_ID_HI:`DLC_DIAG_ID_LO] = BUS_ID;
    diag[`DLC_DIAG_OW_HI:`DLC_DIAG_OW_LO] = s_q.owc.cnt;
    diag[`DLC_DIAG_RDERR_BIT]  = err[2];
    diag[`DLC_DIAG_FFERR_BIT]  = err[1];
    diag[`DLC_DIAG_LSTERR_BIT] = err[0];
    ctrl = 32'h0;
    ctrl[`DLC_CTRL_ACTIVE_BIT] = s_q.active;
    ctrl[`DLC_CTRL_IRQ_BIT]    = s_q.irq;
    ctrl[`DLC_CTRL_ERR_BIT]    = |err;
  end

  // ==========================================================
  // next state
  always_comb
  begin
    s_d = s_q;
    s_d.ack = req;
    // transfer progress
    if (start_i)
    begin
      s_d.active = 1'b1;
      s_d.st = dlc_pkg::DLC_RUN;
    end
    if (beat_i && s_q.st != dlc_pkg::DLC_IDLE)
    begin
      // count saturates at zero
      if (s_q.transfer_byte_count > 16'(beat_bytes_i))
      begin
        s_d.transfer_byte_count = s_q.transfer_byte_count - 16'(beat_bytes_i);
      end
      else
      begin
        s_d.transfer_byte_count = 16'h0000;
        s_d.st = dlc_pkg::DLC_IDLE;
        s_d.active = 1'b0;
      end
    end
    // read error stops the channel but keeps taking beats
    if (rd_resp_err_i)
    begin
      s_d.active = 1'b0;
      s_d.irq = 1'b1;
      if (s_q.st == dlc_pkg::DLC_RUN)
      begin
        s_d.st = dlc_pkg::DLC_DRAIN;
      end
    end
    // outstanding writes
    if (start_i)
    begin
      s_d.owc.cnt = 4'h0;
    end
    else if (wr_issue_i && !wr_resp_i && s_q.owc.cnt != 4'hf)
    begin
      s_d.owc.cnt = s_q.owc.cnt + 4'h1;
    end
    else if (wr_resp_i && !wr_issue_i && s_q.owc.cnt != 4'h0)
    begin
      s_d.owc.cnt = s_q.owc.cnt - 4'h1;
    end
    // engine flags: hardware set wins over software write
    if (wr && adr_i == `DLC_OFS_INTFLAG)
    begin
      if (sel_i[0])
      begin
        s_d.irq_flags[7:0] = dat_i[7:0];
      end
      if (sel_i[1])
      begin
        s_d.irq_flags[NUM_ENG-1:8] = dat_i[NUM_ENG-1:8];
      end
    end
    s_d.irq_flags = s_d.irq_flags | eng_irq_i;
    // register writes
    if (wr)
    begin
      unique case (adr_i)
        `DLC_OFS_LEN:
        begin
          if (sel_i[0])
          begin
            s_d.transfer_byte_count[7:0] = dat_i[7:0];
          end
          if (sel_i[1])
          begin
            s_d.transfer_byte_count[15:8] = dat_i[15:8];
          end
        end
        `DLC_OFS_CTRL:
        begin
          if (sel_i[0] && dat_i[`DLC_CTRL_IRQ_BIT] && !rd_resp_err_i)
          begin
            s_d.irq = 1'b0;
          end
        end
        `DLC_OFS_ENABLE:
        begin
          if (sel_i[0])
          begin
            s_d.eng_on[7:0] = dat_i[7:0];
          end
          if (sel_i[1])
          begin
            s_d.eng_on[NUM_EN-1:8] = dat_i[NUM_EN-1:8];
          end
        end
        default:
        begin
        end
      endcase
    end
    // read data, unmapped reads zero
    s_d.rdata = 32'h0;
    if (req && !we_i)
    begin
      unique case (adr_i)
        `DLC_OFS_LEN:     s_d.rdata = {16'h0000, s_q.transfer_byte_count};
        `DLC_OFS_DIAG:    s_d.rdata = diag;
        `DLC_OFS_CTRL:    s_d.rdata = ctrl;
        `DLC_OFS_INTFLAG: s_d.rdata = 32'(s_q.irq_flags);
        `DLC_OFS_ENABLE:  s_d.rdata = 32'(s_q.eng_on);
        default:          s_d.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
      s_q.transfer_byte_count <= `DLC_LEN_RST;
      s_q.irq_flags <= `DLC_INTFLAG_RST;
      s_q.eng_on <= `DLC_ENABLE_RST;
      s_q.st <= dlc_pkg::DLC_IDLE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  assign dat_o = s_q.rdata;
  assign ack_o = s_q.ack;
  assign active_o = s_q.active;
  assign irq_o = s_q.irq;
  assign eng_on_o = s_q.eng_on;
  assign bus_transaction_id_o = BUS_ID;

  // ==========================================================
  // checks
  chk_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held more than one cycle");
  chk_ack_follows_req: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged next cycle");
  chk_len_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && adr_i == `DLC_OFS_LEN && sel_i == 4'hf && !beat_i
    |=> s_q.transfer_byte_count == $past(dat_i[15:0]))
    else $error("length write not stored");
  chk_len_progress: assert property (@(posedge clk_i) disable iff (rst_i)
    beat_i && s_q.st != dlc_pkg::DLC_IDLE && !wr && s_q.transfer_byte_count > 16'h0
    |=> s_q.transfer_byte_count < $past(s_q.transfer_byte_count))
    else $error("byte count did not progress");
  chk_diag_const: assert property (@(posedge clk_i) disable iff (rst_i)
    diag[31:25] == {3'h0, `DLC_DIAG_LITE_VAL, `DLC_DIAG_REV_VAL})
    else $error("lite bit or revision wrong");
  chk_owc_start: assert property (@(posedge clk_i) disable iff (rst_i)
    start_i |=> s_q.owc.cnt == 4'h0)
    else $error("outstanding count not cleared on start");
  chk_owc_inc: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_issue_i && !wr_resp_i && !start_i && s_q.owc.cnt < 4'hf
    |=> s_q.owc.cnt == $past(s_q.owc.cnt) + 4'h1)
    else $error("outstanding count not incremented");
  chk_err_summary: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl[`DLC_CTRL_ERR_BIT] == (err != 3'h0))
    else $error("summary error bit mismatch");
  chk_rderr_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_resp_err_i |=> !active_o && irq_o && err[2])
    else $error("read error did not stop channel");
  chk_irq_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
    eng_irq_i[0] |=> s_q.irq_flags[0])
    else $error("engine flag not set");
  chk_diag_ro: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && adr_i == `DLC_OFS_DIAG && !start_i && !wr_issue_i && !wr_resp_i
    |=> s_q.owc.cnt == $past(s_q.owc.cnt))
    else $error("read-only field changed by write");
endmodule : dlc_channel

// [tb/dlc_axi_side.sv]
`timescale 1ns/1ps
// far side: one-cycle event pulses, optionally after a stall
module dlc_axi_side
(
  // clock
  input  wire logic       clk_i,
  // events to the channel
  output logic      [6:0] ev_o,
  output logic      [4:0] nb_o
);
  initial
  begin
    ev_o = 7'h0;
    nb_o = 5'h0;
  end
  task automatic send(input logic [6:0] ev, input logic [4:0] nb, input int gap);
    // at least one edge so back-to-back pulses never share a time step
    repeat (gap + 1) @(posedge clk_i);
    ev_o <= ev;
    nb_o <= nb;
    @(posedge clk_i);
    ev_o <= 7'h0;
    nb_o <= ~nb;
  endtask : send
endmodule : dlc_axi_side

// [tb/test_dma_lite_channel_status_regs.sv]
`timescale 1ns/1ps
`include "dlc_defs.svh"
module test_dma_lite_channel_status_regs;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, active_o, irq_o;
  logic [7:0]  adr_i, id_o, a;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic [6:0]  ev;
  logic [4:0]  nb;
  logic [15:0] eng_irq_i, len, intf;
  logic [14:0] eng_on_o, en;
  logic [8:0]  st;
  logic [3:0]  ow;
  logic        act, irq, rde, ffe, lse;
  int          num_errors, n_checks, seed;
  logic [7:0]  at [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
  dlc_channel #(.BUS_ID(8'h5a)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .start_i(ev[0]), .beat_i(ev[1]), .beat_bytes_i(nb),
    .wr_issue_i(ev[2]), .wr_resp_i(ev[3]), .rd_resp_err_i(ev[4]), .fifo_err_i(ev[5]),
    .rd_last_miss_i(ev[6]), .eng_irq_i(eng_irq_i), .active_o(active_o), .irq_o(irq_o),
    .eng_on_o(eng_on_o), .bus_transaction_id_o(id_o));
  dlc_axi_side i_axi (.clk_i(clk_i), .ev_o(ev), .nb_o(nb));
  // ==========================================
  // reference model
  function automatic logic [31:0] msk(input logic [7:0] x);
    case (x)
      8'h00, 8'h0c: return 32'h0000ffff;
      8'h04:        return 32'h1ffffff7;
      8'h08:        return 32'h00000007;
      8'h10:        return 32'h00007fff;
      default:      return 32'hffffffff;
    endcase
  endfunction : msk
  function automatic logic [31:0] expv(input logic [7:0] x);
    case (x)
      8'h00:   return {16'h0, len};
      8'h04:   return {3'h0, `DLC_DIAG_LITE_VAL, `DLC_DIAG_REV_VAL, st, 8'h5a, ow, 1'h0,
                       rde, ffe, lse};
      8'h08:   return {29'h0, rde | ffe | lse, irq, act};
      8'h0c:   return {16'h0, intf};
      8'h10:   return {17'h0, en};
      default: return 32'h0;
    endcase
  endfunction : expv
  task automatic mwrite(input logic [7:0] x, input logic [31:0] d, input logic [3:0] s);
    case (x)
      8'h00:   len = {s[1] ? d[15:8] : len[15:8], s[0] ? d[7:0] : len[7:0]};
      8'h04:   {rde, ffe, lse} = {rde, ffe, lse} & ~(s[0] ? d[2:0] : 3'h0);
      8'h08:   irq = irq & ~(s[0] & d[1]);
      8'h0c:   intf = {s[1] ? d[15:8] : intf[15:8], s[0] ? d[7:0] : intf[7:0]};
      8'h10:   en = {s[1] ? d[14:8] : en[14:8], s[0] ? d[7:0] : en[7:0]};
      default: ;
    endcase
  endtask : mwrite
  // ==========================================
  // checks and bus cycles
  task automatic chk(input logic [31:0] got, input logic [31:0] e, input logic [31:0] m);
    n_checks++;
    if ((got & m) !== (e & m))
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] x, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i  <= w;
    adr_i <= x;
    dat_i <= d;
    sel_i <= s;
    for (n = 0; n < 50 && ack_o !== 1'h1; n++)
      @(posedge clk_i);
    rd = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    if (n == 50)
      num_errors++;
    if (w)
      mwrite(x, d, s);
    else
      chk(rd, expv(x), msk(x));
    chk({15'h0, eng_on_o, irq_o, active_o}, {15'h0, en, irq, act}, 32'h1ffff);
    chk({24'h0, id_o}, 32'h0000005a, 32'h000000ff);
  endtask : wb
  task automatic pulse(input logic [15:0] v);
    @(posedge clk_i);
    eng_irq_i <= v;
    @(posedge clk_i);
    eng_irq_i <= 16'h0;
    intf = intf | v;
  endtask : pulse
  task automatic evt(input int k, input logic [4:0] b);
    i_axi.send(7'(1 << k), b, $unsigned($random(seed)) % 3);
    case (k)
      0: {act, st, ow} = {1'h1, 9'h1, 4'h0};
      1: if (len <= 16'(b)) {len, st, act} = 26'h0; else len = len - 16'(b);
      2: ow = (ow == 4'hf) ? ow : ow + 4'h1;
      3: ow = (ow == 4'h0) ? ow : ow - 4'h1;
      4: {rde, act, irq, st} = {3'h5, (st == 9'h1) ? 9'h2 : st};
      5: ffe = 1'h1;
      6: lse = 1'h1;
      default: ;
    endcase
  endtask : evt
  task automatic close_out;
    if (num_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  // ==========================================
  // sequence
  initial
  begin
    clk_i = 1'h0;
    forever #50 clk_i = ~clk_i;
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    close_out();
  end
  initial
  begin
    {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, eng_irq_i} = {1'h1, 63'h0};
    {len, intf, en, st, ow, act, irq, rde, ffe, lse} = {32'h0, 15'h7fff, 18'h0};
    {num_errors, n_checks, seed} = {64'h0, 32'h4018};
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    for (int i = 0; i < 6; i++)
      wb(1'h0, at[i], 32'h0, 4'hf);
    for (int i = 0; i < 30; i++)
    begin
      a = at[$unsigned($random(seed)) % 6];
      pulse(16'($random(seed)));
      wb(1'h1, a, $random(seed) & msk(a), 4'($random(seed)));
      wb(1'h0, a, 32'h0, 4'hf);
    end
    wb(1'h1, 8'h00, 32'h00000050, 4'h3);
    evt(0, 5'h0);
    for (int i = 0; i < 3; i++)
      evt(2, 5'h0);
    evt(3, 5'h0);
    wb(1'h0, 8'h04, 32'h0, 4'hf);
    for (int i = 0; i < 3; i++)
    begin
      evt(1, 5'(1 + $unsigned($random(seed)) % 16));
      wb(1'h0, 8'h00, 32'h0, 4'hf);
    end
    evt(4, 5'h0);
    wb(1'h0, 8'h04, 32'h0, 4'hf);
    wb(1'h0, 8'h08, 32'h0, 4'hf);
    while (len != 16'h0)
    begin
      evt(1, 5'(1 + $unsigned($random(seed)) % 16));
      wb(1'h0, 8'h00, 32'h0, 4'hf);
    end
    wb(1'h0, 8'h04, 32'h0, 4'hf);
    evt(0, 5'h0);
    wb(1'h0, 8'h04, 32'h0, 4'hf);
    evt(5, 5'h0);
    evt(6, 5'h0);
    wb(1'h0, 8'h08, 32'h0, 4'hf);
    wb(1'h1, 8'h04, 32'h0, 4'hf);
    wb(1'h0, 8'h04, 32'h0, 4'hf);
    wb(1'h1, 8'h04, 32'h00000007, 4'h1);
    wb(1'h1, 8'h08, 32'h00000002, 4'h1);
    wb(1'h0, 8'h08, 32'h0, 4'hf);
    for (int i = 0; i < 17; i++)
      evt(2, 5'h0);
    wb(1'h0, 8'h04, 32'h0, 4'hf);
    for (int i = 0; i < 17; i++)
      evt(3, 5'h0);
    wb(1'h0, 8'h04, 32'h0, 4'hf);
    // mid-run reset with live count, length and enables
    wb(1'h1, 8'h00, 32'h00001234, 4'h3);
    wb(1'h1, 8'h10, 32'h0, 4'h3);
    for (int i = 0; i < 3; i++)
      evt(2, 5'h0);
    @(posedge clk_i);
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    {len, intf, en, st, ow, act, irq, rde, ffe, lse} = {32'h0, 15'h7fff, 18'h0};
    wb(1'h0, 8'h04, 32'h0, 4'hf);
    wb(1'h0, 8'h10, 32'h0, 4'hf);
    wb(1'h0, 8'h00, 32'h0, 4'hf);
    close_out();
  end
endmodule : test_dma_lite_channel_status_regs
